// >>> verilog/rsi_controller.sv
// Interlock, warm-up timing, hour totals and fire sequencing for one rf station
`timescale 1ns/1ps
module rsi_controller #(
	// Warm-up counts exceed 32 bits at the full clock rate, so they are 64-bit figures
	parameter longint HEATER_WARM_CYC = longint'(rsi_pkg::HEATER_WARM_S) * rsi_pkg::SEC_CYC,
	parameter longint THYR_WARM_CYC = longint'(rsi_pkg::THYR_WARM_S) * rsi_pkg::SEC_CYC,
	parameter int SEC_CYC = rsi_pkg::SEC_CYC,
	parameter int HOUR_S = rsi_pkg::HOUR_S,
	parameter int FIRE_DELAY_CYC = rsi_pkg::TRIG_LEAD_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic body_temp_high,
	input wire logic window_temp_high,
	input wire logic klys_vacuum_fault,
	input wire logic heater_current_ok,
	input wire logic [rsi_pkg::ADC_W-1:0] cathode_voltage,
	input wire logic [rsi_pkg::ADC_W-1:0] cathode_current,
	input wire logic [rsi_pkg::ADC_W-1:0] overvoltage_limit,
	input wire logic [rsi_pkg::ADC_W-1:0] overcurrent_limit,
	input wire logic wg_vacuum_fault,
	input wire logic [rsi_pkg::NUM_DET-1:0] detector_trip,
	input wire logic reflected_power_trip,
	input wire logic arc_clipper_current,
	input wire logic hv_supply_overcurrent,
	input wire logic [rsi_pkg::NUM_WATER-1:0] water_flow_ok,
	input wire logic thyratron_energized,
	input wire logic hv_on,
	input wire logic interlock_reset,
	input wire logic [rsi_pkg::NUM_TRIP-1:0] trip_enable,
	input wire logic mpc_trigger,
	output logic rf_drive_enable_ff,
	output logic beam_enable_ff,
	output logic rf_fast_inhibit_ff,
	output logic mpc_ready_ff,
	output logic modulator_fire_ff,
	output logic [rsi_pkg::NUM_TRIP-1:0] trip_latch_ff,
	output logic heater_warm_done_ff,
	output logic thyratron_warm_done_ff,
	output logic [rsi_pkg::HOURS_W-1:0] heater_hours_ff,
	output logic [rsi_pkg::HOURS_W-1:0] hv_hours_ff,
	output logic [rsi_pkg::HOURS_W-1:0] thyratron_hours_ff
);
	// ********************
	// Input synchronisers
	// ********************
	localparam int NSYNC = 14 + rsi_pkg::NUM_DET + rsi_pkg::NUM_WATER;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;
	// Water bits reset to the flow ok level, else every reset would latch a false water trip
	localparam logic [NSYNC-1:0] SYNC_RST = {{rsi_pkg::NUM_WATER{1'b1}}, {(NSYNC - rsi_pkg::NUM_WATER){1'b0}}};
	assign raw_in = {water_flow_ok, detector_trip, mpc_trigger, interlock_reset, hv_on, thyratron_energized,
		hv_supply_overcurrent, arc_clipper_current, reflected_power_trip, wg_vacuum_fault, heater_current_ok,
		klys_vacuum_fault, window_temp_high, body_temp_high, 2'b00};
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_ff <= SYNC_RST;
			sync2_ff <= SYNC_RST;
		end else begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
		end
	end
	logic s_body, s_window, s_kvac, s_heat_ok, s_wgvac, s_refl, s_arc, s_hv_supply_overcurrent;
	logic s_thyr, s_hv, s_rst, s_trig;
	logic [rsi_pkg::NUM_DET-1:0] s_det;
	logic [rsi_pkg::NUM_WATER-1:0] s_water;
	assign s_body = sync2_ff[2];
	assign s_window = sync2_ff[3];
	assign s_kvac = sync2_ff[4];
	assign s_heat_ok = sync2_ff[5];
	assign s_wgvac = sync2_ff[6];
	assign s_refl = sync2_ff[7];
	assign s_arc = sync2_ff[8];
	assign s_hv_supply_overcurrent = sync2_ff[9];
	assign s_thyr = sync2_ff[10];
	assign s_hv = sync2_ff[11];
	assign s_rst = sync2_ff[12];
	assign s_trig = sync2_ff[13];
	assign s_det = sync2_ff[14 +: rsi_pkg::NUM_DET];
	assign s_water = sync2_ff[14 + rsi_pkg::NUM_DET +: rsi_pkg::NUM_WATER];

	// Digitized values are sampled twice too; a torn word only costs one late compare
	// Limits ride the same two flops, so a value is never compared against a newer limit
	logic [rsi_pkg::ADC_W-1:0] cv1_ff, cv2_ff, ci1_ff, ci2_ff;
	logic [rsi_pkg::ADC_W-1:0] ovl1_ff, ovl2_ff, ocl1_ff, ocl2_ff;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cv1_ff <= '0;
			cv2_ff <= '0;
			ci1_ff <= '0;
			ci2_ff <= '0;
			ovl1_ff <= '0;
			ovl2_ff <= '0;
			ocl1_ff <= '0;
			ocl2_ff <= '0;
		end else begin
			cv1_ff <= cathode_voltage;
			cv2_ff <= cv1_ff;
			ci1_ff <= cathode_current;
			ci2_ff <= ci1_ff;
			ovl1_ff <= overvoltage_limit;
			ovl2_ff <= ovl1_ff;
			ocl1_ff <= overcurrent_limit;
			ocl2_ff <= ocl1_ff;
		end
	end

	// ********************
	// Warm-up timers
	// ********************
	logic [39:0] heat_cnt_ff;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			heat_cnt_ff <= '0;
			heater_warm_done_ff <= 1'b0;
		end else if (!s_heat_ok) begin
			heat_cnt_ff <= '0;
			heater_warm_done_ff <= 1'b0;
		end else if (heat_cnt_ff >= 40'(HEATER_WARM_CYC - 1)) begin
			heater_warm_done_ff <= 1'b1;
		end else begin
			heat_cnt_ff <= heat_cnt_ff + 40'h1;
		end
	end
	logic [39:0] thyr_cnt_ff;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			thyr_cnt_ff <= '0;
			thyratron_warm_done_ff <= 1'b0;
		end else if (!s_thyr) begin
			thyr_cnt_ff <= '0;
			thyratron_warm_done_ff <= 1'b0;
		end else if (thyr_cnt_ff >= 40'(THYR_WARM_CYC - 1)) begin
			thyratron_warm_done_ff <= 1'b1;
		end else begin
			thyr_cnt_ff <= thyr_cnt_ff + 40'h1;
		end
	end

	// ********************
	// Fault detection and latching
	// ********************
	logic [rsi_pkg::NUM_TRIP-1:0] fault_now;
	always_comb begin
		fault_now = '0;
		fault_now[rsi_pkg::T_BODY] = s_body;
		fault_now[rsi_pkg::T_WINDOW] = s_window;
		fault_now[rsi_pkg::T_KVAC] = s_kvac;
		fault_now[rsi_pkg::T_HEATER] = !s_heat_ok;
		fault_now[rsi_pkg::T_OVERV] = cv2_ff > ovl2_ff;
		fault_now[rsi_pkg::T_OVERI] = ci2_ff > ocl2_ff;
		fault_now[rsi_pkg::T_WGVAC] = s_wgvac;
		fault_now[rsi_pkg::T_DET] = |s_det;
		fault_now[rsi_pkg::T_REFL] = s_refl;
		fault_now[rsi_pkg::T_ARC] = s_arc;
		fault_now[rsi_pkg::T_HV_SUPPLY_OVERCURRENT] = s_hv_supply_overcurrent;
		fault_now[rsi_pkg::T_WATER] = !(&s_water);
		fault_now[rsi_pkg::T_THYR] = !thyratron_warm_done_ff;
	end
	// Warm-up related bits are conditions, not trips, so they follow live and never latch
	localparam logic [15:0] LIVE_MASK = 16'h1008;
	genvar gi;
	generate
		for (gi = 0; gi < rsi_pkg::NUM_TRIP; gi++) begin : g_trip
			always_ff @(posedge clk) begin
				if (!nrst) begin
					trip_latch_ff[gi] <= rsi_pkg::TRIP_RST[gi];
				end else if (LIVE_MASK[gi]) begin
					trip_latch_ff[gi] <= fault_now[gi] & trip_enable[gi];
				end else if (fault_now[gi] && trip_enable[gi]) begin
					trip_latch_ff[gi] <= 1'b1;
				end else if (s_rst) begin
					trip_latch_ff[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ********************
	// Inhibit outputs
	// ********************
	localparam logic [15:0] BEAM_MASK = 16'h1e3d;
	localparam logic [15:0] RF_MASK = 16'h03c2;
	logic beam_block, rf_block;
	assign beam_block = |(trip_latch_ff & BEAM_MASK) || !heater_warm_done_ff;
	assign rf_block = |(trip_latch_ff & RF_MASK) || beam_block;

	rsi_pkg::rsi_seq_type seq_ff;
	logic fire_window;
	assign fire_window = (seq_ff != rsi_pkg::SEQ_IDLE);
	always_ff @(posedge clk) begin
		if (!nrst) begin
			beam_enable_ff <= 1'b0;
			rf_drive_enable_ff <= 1'b0;
		end else if (fire_window && mpc_ready_ff) begin
			beam_enable_ff <= 1'b1;
			rf_drive_enable_ff <= !rf_fast_inhibit_ff;
		end else begin
			beam_enable_ff <= !beam_block;
			rf_drive_enable_ff <= !rf_block;
		end
	end
	// Fast path reads only the raw pin through two flops, bypassing latches and sequencing
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rf_fast_inhibit_ff <= 1'b0;
		end else begin
			rf_fast_inhibit_ff <= s_refl;
		end
	end

	// ********************
	// Trigger and firing sequence
	// ********************
	logic trig_d_ff;
	logic trig_rise;
	logic [31:0] fire_cnt_ff;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			trig_d_ff <= 1'b0;
		end else begin
			trig_d_ff <= s_trig;
		end
	end
	assign trig_rise = s_trig && !trig_d_ff;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			seq_ff <= rsi_pkg::SEQ_IDLE;
			fire_cnt_ff <= '0;
			mpc_ready_ff <= 1'b0;
			modulator_fire_ff <= 1'b0;
		end else begin
			modulator_fire_ff <= 1'b0;
			case (seq_ff)
				rsi_pkg::SEQ_IDLE: begin
					mpc_ready_ff <= 1'b0;
					if (trig_rise) begin
						// Readiness decided once, from the state at the trigger
						mpc_ready_ff <= !beam_block && thyratron_warm_done_ff;
						fire_cnt_ff <= '0;
						seq_ff <= rsi_pkg::SEQ_ARMED;
					end
				end
				rsi_pkg::SEQ_ARMED: begin
					// trigger leads beam time, so the charge delay fits in the lead
					if (fire_cnt_ff >= 32'(FIRE_DELAY_CYC - 3)) begin
						seq_ff <= rsi_pkg::SEQ_FIRE;
					end else begin
						fire_cnt_ff <= fire_cnt_ff + 32'h1;
					end
				end
				rsi_pkg::SEQ_FIRE: begin
					modulator_fire_ff <= mpc_ready_ff;
					seq_ff <= rsi_pkg::SEQ_IDLE;
				end
				default: begin
					seq_ff <= rsi_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	// ********************
	// Operating hour totals
	// ********************
	logic sec_tick;
	logic [31:0] sec_cnt_ff;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sec_cnt_ff <= '0;
		end else if (sec_cnt_ff >= 32'(SEC_CYC - 1)) begin
			sec_cnt_ff <= '0;
		end else begin
			sec_cnt_ff <= sec_cnt_ff + 32'h1;
		end
	end
	assign sec_tick = (sec_cnt_ff >= 32'(SEC_CYC - 1));
	logic [2:0] run_on;
	logic [11:0] run_sec_ff [3];
	logic [rsi_pkg::HOURS_W-1:0] hours [3];
	assign run_on = {s_thyr, s_hv, s_heat_ok};
	generate
		for (gi = 0; gi < 3; gi++) begin : g_hours
			always_ff @(posedge clk) begin
				if (!nrst) begin
					run_sec_ff[gi] <= '0;
					hours[gi] <= rsi_pkg::HOURS_RST;
				end else if (sec_tick && run_on[gi]) begin
					if (run_sec_ff[gi] >= 12'(HOUR_S - 1)) begin
						run_sec_ff[gi] <= '0;
						hours[gi] <= hours[gi] + 24'h1;
					end else begin
						run_sec_ff[gi] <= run_sec_ff[gi] + 12'h1;
					end
				end
			end
		end
	endgenerate
	// Totals are logged data to the central computer; trip_enable is its configuration
	assign heater_hours_ff = hours[0];
	assign hv_hours_ff = hours[1];
	assign thyratron_hours_ff = hours[2];
endmodule

// >>> shared/rsi_pkg.sv
// Constants shared by the rf station interlock controller
package rsi_pkg;
	// ********************
	// Timing
	// ********************
	localparam int CLK_HZ = 20000000;
	localparam int TRIG_LEAD_US = 100;
	localparam int TRIG_LEAD_CYC = (TRIG_LEAD_US * (CLK_HZ / 1000000));
	localparam int HOUR_S = 3600;
	localparam int SEC_CYC = CLK_HZ;
	localparam int HEATER_WARM_S = 300;
	localparam int THYR_WARM_S = 300;
	localparam int FIRE_PULSE_CYC = 1;
	// ********************
	// Widths and layout
	// ********************
	localparam int ADC_W = 12;
	localparam int HOURS_W = 24;
	localparam int NUM_WATER = 6;
	localparam int NUM_DET = 4;
	localparam int NUM_TRIP = 16;
	// Trip bit positions
	localparam int T_BODY = 0;
	localparam int T_WINDOW = 1;
	localparam int T_KVAC = 2;
	localparam int T_HEATER = 3;
	localparam int T_OVERV = 4;
	localparam int T_OVERI = 5;
	localparam int T_WGVAC = 6;
	localparam int T_DET = 7;
	localparam int T_REFL = 8;
	localparam int T_ARC = 9;
	localparam int T_HV_SUPPLY_OVERCURRENT = 10;
	localparam int T_WATER = 11;
	localparam int T_THYR = 12;
	// Reset values
	localparam logic [15:0] TRIP_RST = 16'h0000;
	localparam logic [HOURS_W-1:0] HOURS_RST = 24'h000000;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ARMED = 2'b01,
		SEQ_FIRE = 2'b10
	} rsi_seq_type;
endpackage

// >>> tb/rsi_mpc_model.sv
// Machine protection controller model: sends the trigger, collects readiness and fire
`timescale 1ns/1ps
module rsi_mpc_model (
	input wire logic clk,
	input wire logic go,
	input wire logic ready,
	input wire logic fire,
	output logic trigger,
	output logic confirmed,
	output logic fired
);
	initial begin
		trigger = 1'b0;
		confirmed = 1'b0;
		fired = 1'b0;
	end
	// Trigger held until readiness shows; a station not ready at the trigger's rise is never confirmed
	always @(posedge clk) begin
		if (go) begin
			trigger <= 1'b1;
			confirmed <= 1'b0;
			fired <= 1'b0;
		end
		if (trigger && ready) begin
			trigger <= 1'b0;
			confirmed <= 1'b1;
		end
		if (fire) begin
			fired <= 1'b1;
		end
	end
endmodule

// >>> tb/rsi_controller_asserts.sv
// Concurrent checks on the station controller ports
`timescale 1ns/1ps
module rsi_controller_asserts (
	input wire logic clk,
	input wire logic nrst,
	input wire logic body_temp_high,
	input wire logic window_temp_high,
	input wire logic klys_vacuum_fault,
	input wire logic [rsi_pkg::ADC_W-1:0] cathode_voltage,
	input wire logic [rsi_pkg::ADC_W-1:0] overvoltage_limit,
	input wire logic reflected_power_trip,
	input wire logic interlock_reset,
	input wire logic [rsi_pkg::NUM_TRIP-1:0] trip_enable,
	input wire logic mpc_trigger,
	input wire logic beam_enable_ff,
	input wire logic rf_fast_inhibit_ff,
	input wire logic mpc_ready_ff,
	input wire logic modulator_fire_ff,
	input wire logic [rsi_pkg::NUM_TRIP-1:0] trip_latch_ff
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// ********************
	// Trips
	// ********************
	a_body_trip: assert property (body_temp_high && trip_enable[0] |-> ##3 trip_latch_ff[0])
		else $error("body trip missing");
	a_window_trip: assert property (window_temp_high && trip_enable[1] |-> ##3 trip_latch_ff[1])
		else $error("window trip missing");
	a_vacuum_trip: assert property (klys_vacuum_fault && trip_enable[2] |-> ##3 trip_latch_ff[2])
		else $error("vacuum trip missing");
	a_overvolt_trip: assert property (cathode_voltage > overvoltage_limit && trip_enable[4] |-> ##3 trip_latch_ff[4])
		else $error("overvoltage trip missing");
	a_beam_block: assert property (trip_latch_ff[0] && !mpc_ready_ff |=> !beam_enable_ff || mpc_ready_ff)
		else $error("beam left on");
	a_fast_path: assert property (reflected_power_trip |-> ##3 rf_fast_inhibit_ff)
		else $error("fast inhibit late");
	// Second reset of one edge would look like a fall, hence the past reset term
	a_trip_hold: assert property ($fell(trip_latch_ff[0]) && $past(nrst) |-> $past(interlock_reset, 3))
		else $error("trip cleared without reset");
	// ********************
	// Fire sequence
	// ********************
	a_ready_cause: assert property ($rose(mpc_ready_ff) |-> $past(mpc_trigger, 3))
		else $error("ready without trigger");
	a_ready_beam: assert property (mpc_ready_ff && $past(mpc_ready_ff) |-> beam_enable_ff)
		else $error("beam blocked after ready");
	a_fire_ready: assert property (modulator_fire_ff |-> $past(mpc_ready_ff))
		else $error("fire without ready");
	a_fire_pulse: assert property (modulator_fire_ff |=> !modulator_fire_ff)
		else $error("fire pulse too long");
	c_fire: cover property (modulator_fire_ff);
	c_ready: cover property ($rose(mpc_ready_ff));
	c_body: cover property ($rose(trip_latch_ff[0]));
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the station interlock controller
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", n, e, a); end end
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic heat = 1'b0, thy = 1'b0, hv = 1'b0, irst = 1'b0, go = 1'b0;
	logic [11:0] flt = 12'h000;
	logic [11:0] lim = 12'h400;
	logic [3:0] det = 4'h1;
	logic [5:0] wat = 6'h3f;
	logic [15:0] ten = 16'hffff;
	logic [31:0] rng = 32'h73747e5b;
	int bad_count = 0;
	int tests_run = 0;
	logic trig, rdy, fire, rfen, ben, fi, wh, wt, conf, fired;
	logic [15:0] tl;
	logic [23:0] hh, vh, th;
	always #25 clk = ~clk;
	rsi_mpc_model u_mpc (.clk(clk), .go(go), .ready(rdy), .fire(fire), .trigger(trig), .confirmed(conf),
		.fired(fired));
	rsi_controller #(.HEATER_WARM_CYC(20), .THYR_WARM_CYC(20), .SEC_CYC(10), .HOUR_S(3), .FIRE_DELAY_CYC(20)) u_dut (
		.clk(clk), .nrst(nrst), .body_temp_high(flt[0]), .window_temp_high(flt[1]), .klys_vacuum_fault(flt[2]),
		.heater_current_ok(heat), .cathode_voltage(lim + {11'h0, flt[4]}), .cathode_current(lim + {11'h0, flt[5]}),
		.overvoltage_limit(lim), .overcurrent_limit(lim), .wg_vacuum_fault(flt[6]),
		.detector_trip(flt[7] ? det : 4'h0), .reflected_power_trip(flt[8]), .arc_clipper_current(flt[9]),
		.hv_supply_overcurrent(flt[10]), .water_flow_ok(wat), .thyratron_energized(thy), .hv_on(hv),
		.interlock_reset(irst), .trip_enable(ten), .mpc_trigger(trig), .rf_drive_enable_ff(rfen),
		.beam_enable_ff(ben), .rf_fast_inhibit_ff(fi), .mpc_ready_ff(rdy), .modulator_fire_ff(fire),
		.trip_latch_ff(tl), .heater_warm_done_ff(wh), .thyratron_warm_done_ff(wt), .heater_hours_ff(hh),
		.hv_hours_ff(vh), .thyratron_hours_ff(th));
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Faults that must also stop the beam, not only the rf drive
	function automatic logic beam_ok(int k);
		return !(k inside {0, 2, 4, 5, 9, 10, 11});
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic hang_check(logic v);
		`CHK("handshake", 1'b1, v)
		if (v !== 1'b1) close_out();
	endtask
	task automatic clear_trips();
		flt = 12'h000;
		wat = 6'h3f;
		irst = 1'b1;
		tick(3);
		irst = 1'b0;
		tick(3);
	endtask
	initial begin
		int k;
		int n;
		// ********************
		// Reset and warm-up
		// ********************
		tick(4);
		nrst = 1'b1;
		tick(1);
		`CHK("hours", 24'h000000, hh)
		tick(4);
		`CHK("heater trip", 1'b1, tl[3])
		heat = 1'b1;
		thy = 1'b1;
		tick(10);
		`CHK("beam early", 1'b0, ben)
		tick(25);
		`CHK("heater warm", 1'b1, wh)
		`CHK("thyratron warm", 1'b1, wt)
		`CHK("beam", 1'b1, ben)
		$display("end of warm-up test");
		// ********************
		// Every latching interlock, latched until reset
		// ********************
		for (k = 0; k < 12; k++) begin
			if (k == 3) continue;
			rng = lfsr(rng);
			lim = {2'b01, rng[9:0]};
			det = 4'h1 << rng[11:10];
			flt = 12'h001 << k;
			wat = flt[11] ? ~(6'h01 << (rng[14:12] % 3'h6)) : 6'h3f;
			tick(5);
			`CHK("trip", 1'b1, tl[k])
			`CHK("rf", 1'b0, rfen)
			`CHK("beam", beam_ok(k), ben)
			if (k == 8) `CHK("fast", 1'b1, fi)
			flt = 12'h000;
			wat = 6'h3f;
			tick(5);
			`CHK("held", 1'b1, tl[k])
			clear_trips();
			`CHK("cleared", 1'b0, tl[k])
			`CHK("rf back", 1'b1, rfen)
		end
		ten[0] = 1'b0;
		flt = 12'h001;
		tick(5);
		`CHK("masked", 1'b0, tl[0])
		flt = 12'h000;
		// Let the synchronised fault drain before the trip is enabled again
		tick(3);
		ten[0] = 1'b1;
		tick(2);
		`CHK("masked clean", 1'b0, tl[0])
		$display("end of interlock test");
		// ********************
		// Trigger, readiness and fire despite a fault
		// ********************
		go = 1'b1;
		tick(1);
		go = 1'b0;
		for (n = 0; n < 20 && rdy !== 1'b1; n++) tick(1);
		hang_check(rdy);
		flt = 12'h001;
		for (n = 0; n < 60 && fire !== 1'b1; n++) tick(1);
		hang_check(fire);
		`CHK("confirmed", 1'b1, conf)
		tick(3);
		`CHK("beam after fire", 1'b0, ben)
		`CHK("fired", 1'b1, fired)
		clear_trips();
		$display("end of fire test");
		`CHK("hv idle", 24'h000000, vh)
		hv = 1'b1;
		tick(100);
		`CHK("hv hours", 1'b1, vh inside {24'h2, 24'h3, 24'h4})
		`CHK("heater hours", 1'b1, hh != 24'h0)
		`CHK("thyratron hours", 1'b1, th != 24'h0)
		$display("end of hours test");
		close_out();
	end
endmodule
bind rsi_controller rsi_controller_asserts u_chk (.clk, .nrst, .body_temp_high, .window_temp_high,
	.klys_vacuum_fault, .cathode_voltage, .overvoltage_limit, .reflected_power_trip, .interlock_reset,
	.trip_enable, .mpc_trigger, .beam_enable_ff, .rf_fast_inhibit_ff, .mpc_ready_ff, .modulator_fire_ff,
	.trip_latch_ff);
